// *** dv/fbioc_master.sv ***
// network master model: sends output frames and polls input frames
`timescale 1ns/1ps
module fbioc_master (
   // clock
   input wire logic clk,
   // payload pins toward the codec
   output logic rx_valid,
   output logic [63:0] rx_data,
   output logic tx_req,
   input wire logic tx_valid,
   input wire logic [63:0] tx_data
);
   // ==========================================
   // idle lines at time zero
   initial begin
      rx_valid = 1'b0;
      rx_data = 64'h0;
      tx_req = 1'b0;
   end
   // one frame for one cycle; afterwards the data lines show its inverse
   // so that a stale frame can never pass for a fresh one
   task automatic send(input logic [63:0] f);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= f;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~f;
   endtask
   // per-unit speed word with the maximum speed counting 20000
   function automatic logic [15:0] pu(input int rpm, input int mx);
      return 16'(rpm * 20000 / mx);
   endfunction
   // poll, then take the answer at the edge where it is sampled
   task automatic poll(output logic [63:0] q, output logic v);
      @(posedge clk);
      tx_req <= 1'b1;
      @(posedge clk);
      tx_req <= 1'b0;
      @(posedge clk);
      v = tx_valid;
      q = tx_data;
   endtask
endmodule

// *** dv/fbioc_top_asserts.sv ***
// concurrent checks on the codec's payload and command ports
`timescale 1ns/1ps
module fbioc_top_asserts (
   // clock and reset
   input wire logic CLOCK,
   input wire logic SRST,
   // payload handshake
   input wire logic RX_VALID,
   input wire logic TX_REQ,
   input wire logic TX_VALID,
   input wire logic [63:0] TX_DATA,
   // drive commands and parameter writes
   input wire logic ALARM_CLEAR,
   input wire logic [15:0] SPEED_CMD_RPM,
   input wire logic [3:0] PARAM_WR_STB,
   input wire logic [63:0] PARAM_WR_CODE,
   input wire logic [63:0] PARAM_WR_DATA
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SRST);
   // ==========================================
   // strobed word aimed at target 0 or at one a higher selector names
   logic bad_stb;
   always_comb begin
      bad_stb = 1'b0;
      for (int i = 0; i < 4; i++) begin
         for (int j = i; j < 4; j++) begin
            if (PARAM_WR_STB[i] && PARAM_WR_CODE[16*i+:16] ==
               (j == i ? 16'h0000 : PARAM_WR_CODE[16*j+:16])) begin
               bad_stb = 1'b1;
            end
         end
      end
   end
   // answers only to polls, and the payload never changes unasked
   property p_poll_ans; TX_REQ |=> TX_VALID; endproperty
   a_poll_ans: assert property (p_poll_ans)
      else $error("poll not answered on the next cycle");
   property p_tx_hold; !TX_REQ |=> !TX_VALID && $stable(TX_DATA); endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("input payload moved without a poll");
   property p_upper_zero; TX_VALID |-> TX_DATA[63:32] == 32'h0; endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("unused input bytes not zero");
   // command outputs move only on a received frame
   property p_clr_cause; ALARM_CLEAR |-> $past(RX_VALID); endproperty
   a_clr_cause: assert property (p_clr_cause)
      else $error("alarm clear without a frame");
   property p_stb_cause; |PARAM_WR_STB |-> $past(RX_VALID); endproperty
   a_stb_cause: assert property (p_stb_cause)
      else $error("parameter write without a frame");
   property p_spd_hold; !RX_VALID |=> $stable(SPEED_CMD_RPM); endproperty
   a_spd_hold: assert property (p_spd_hold)
      else $error("speed command moved without a frame");
   property p_wr_hold;
      !RX_VALID |=> $stable(PARAM_WR_DATA) && $stable(PARAM_WR_CODE);
   endproperty
   a_wr_hold: assert property (p_wr_hold)
      else $error("parameter word moved without a frame");
   property p_one_target; !bad_stb; endproperty
   a_one_target: assert property (p_one_target)
      else $error("write strobe on an unassigned or shadowed target");
endmodule

// *** dv/fbioc_top_test.sv ***
// self-checking bench of the i/o assembly codec
`timescale 1ns/1ps
`include "fbioc_cfg.svh"
module fbioc_top_test;
   // ==========================================
   // bench signals, clock and reset
   logic clk = 1'b0, srst = 1'b1;
   logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic [7:0] awa = 8'h0, ara = 8'h0;
   logic [31:0] wd = 32'h0, rd;
   logic awr, wrd, bv, arr, rv, rxv, txq, txv;
   logic ahead, back, aclr, nrun, nspd;
   logic [1:0] bresp, rresp;
   logic [63:0] rxd, txd, code, wdat;
   logic [15:0] spd;
   logic [12:0] vt;
   logic [3:0] stb;
   int n_mismatch = 0, checked = 0;
   wire logic [33:0] cmds = {ahead, back, aclr, nrun, nspd, spd, vt};
   always #10 clk = ~clk;
   fbioc_top i_dut (.CLOCK(clk), .SRST(srst), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrd), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp),
      .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rd),
      .S_AXI_RRESP(rresp), .RX_VALID(rxv), .RX_DATA(rxd), .TX_REQ(txq),
      .TX_VALID(txv), .TX_DATA(txd), .RUN_AHEAD(ahead),
      .RUN_BACKWARD(back), .ALARM_CLEAR(aclr), .NET_RUN_SOURCE_REQ(nrun),
      .NET_SPEED_SOURCE_REQ(nspd), .SPEED_CMD_RPM(spd),
      .VIRTUAL_TERMINAL_CMDS(vt), .PARAM_WR_STB(stb),
      .PARAM_WR_CODE(code), .PARAM_WR_DATA(wdat));
   fbioc_master i_master (.clk(clk), .rx_valid(rxv), .rx_data(rxd),
      .tx_req(txq), .tx_valid(txv), .tx_data(txd));
   // compare and count
   task automatic check(input string n, input logic [79:0] s, e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // one axi4-lite transfer; address and data share one ready flop
   task automatic axi(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
      @(posedge clk);
      awa <= a;
      ara <= a;
      wd <= d;
      awv <= w;
      wv <= w;
      br <= w;
      arv <= !w;
      rr <= !w;
      do @(posedge clk); while (!(w ? awr : arr));
      awv <= 1'b0;
      wv <= 1'b0;
      arv <= 1'b0;
      do @(posedge clk); while (!(w ? bv : rv));
      br <= 1'b0;
      rr <= 1'b0;
      q = rd;
      r = w ? bresp : rresp;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic [1:0] r;
      axi(1'b1, a, d, q, r);
   endtask
   task automatic rdc(input string n, input logic [7:0] a,
         input logic [31:0] e);
      logic [31:0] q;
      logic [1:0] r;
      axi(1'b0, a, 32'h0, q, r);
      check(n, {r, q}, {2'h0, e});
   endtask
   // reset values, a read-only place and an unmapped one
   task automatic t_regs();
      logic [31:0] q;
      logic [1:0] r;
      rdc("fmt", `FB_OFS_FMT, 32'h0);
      rdc("active", `FB_OFS_APPLY, 32'h0202);
      rdc("maxspd", `FB_OFS_MAXSPD, 32'h05dc);
      axi(1'b1, `FB_OFS_CMDSTAT, 32'h1, q, r);
      check("ro resp", r, `FB_RESP_SLVERR);
      axi(1'b0, 8'h24, 32'h0, q, r);
      check("unmapped", {q, r}, {32'h0, `FB_RESP_DECERR});
      $display("done regs");
   endtask
   // extended output: every command bit, then run ahead with only unused bits
   task automatic t_ext_out();
      i_master.send({32'h0, 16'h1234, 8'h00, 8'h67});
      @(negedge clk);
      check("ext cmds", cmds, {5'h1f, 16'h1234, 13'h0});
      i_master.send({32'h0, 16'hfc18, 8'h00, 8'h99});
      @(negedge clk);
      check("ext cmds", cmds, {5'h10, 16'hfc18, 13'h0});
      $display("done ext out");
   endtask
   // extended input for state codes 1 to 7, flags on and off
   task automatic t_ext_in();
      logic [63:0] q;
      logic v;
      logic [79:0] e;
      wreg(`FB_OFS_MEAS, 32'h0abc);
      for (int s = 1; s < 8; s++) begin
         wreg(`FB_OFS_DRVSTAT, {5'h0, 3'(s), s[0] ? 24'h03ffff : 24'h0});
         i_master.poll(q, v);
         e = {33'h1_0000_0000, 16'h0abc, 8'(s), s[0] ? 8'hfd : 8'h00};
         check("ext in", {v, q}, e);
      end
      $display("done ext in");
   endtask
   // vendor formats after a restart while stopped
   task automatic t_vend();
      logic [63:0] q;
      logic v;
      wreg(`FB_OFS_DRVSTAT, 32'h0300_0000);
      wreg(`FB_OFS_FMT, {16'h0, `FB_ISEL_VEND, `FB_OSEL_VEND});
      wreg(`FB_OFS_APPLY, 32'h1);
      rdc("active", `FB_OFS_APPLY, 32'h0404);
      i_master.send({32'h0, i_master.pu(750, 1500), 8'haa, 8'hfd});
      @(negedge clk);
      check("vend cmds", cmds, {5'h14, 16'h02ee, 7'h2a, 6'h3f});
      wreg(`FB_OFS_MEAS, 32'd750);
      wreg(`FB_OFS_LINK, 32'h1);
      wreg(`FB_OFS_DRVSTAT, 32'h0303_ffff);
      i_master.poll(q, v);
      check("vend in", {v, q}, {1'b1, 64'h2710_dfff});
      wreg(`FB_OFS_LINK, 32'h0);
      wreg(`FB_OFS_DRVSTAT, 32'h0300_0400);
      i_master.poll(q, v);
      check("vend in", {v, q}, {1'b1, 64'h2710_0020});
      $display("done vendor");
   endtask
   // user format: refused restart, mixed selectors, shared targets
   task automatic t_user();
      logic [63:0] q;
      logic v;
      wreg(`FB_OFS_DRVSTAT, 32'h0500_0000);
      wreg(`FB_OFS_FMT, {16'h0, `FB_ISEL_U485, `FB_OSEL_ULINK});
      wreg(`FB_OFS_APPLY, 32'h1);
      rdc("running", `FB_OFS_APPLY, 32'h0404);
      wreg(`FB_OFS_DRVSTAT, 32'h0300_0000);
      wreg(`FB_OFS_APPLY, 32'h1);
      rdc("mixed", `FB_OFS_APPLY, 32'h0808);
      wreg(`FB_OFS_WSEL01, 32'h0102_0102);
      wreg(`FB_OFS_WSEL23, 32'h0300_0000);
      i_master.send(64'h4444_3333_2222_1111);
      @(negedge clk);
      check("strobes", stb, 4'b1010);
      check("words", wdat, 64'h4444_3333_2222_1111);
      check("targets", code[63:16], 48'h0300_0000_0102);
      check("kept", cmds, {5'h10, 16'h02ee, 7'h2a, 6'h3f});
      i_master.poll(q, v);
      check("user in", {v, q}, {1'b1, 64'h0});
      wreg(`FB_OFS_FMT, {16'h0, `FB_ISEL_EXT, `FB_OSEL_EXT});
      wreg(`FB_OFS_APPLY, 32'h1);
      rdc("coded", `FB_OFS_APPLY, 32'h0202);
      $display("done user");
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // main sequence after three reset cycles
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_ext_out();
      t_ext_in();
      t_vend();
      t_user();
      finish_test();
   end
   // the tests need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      finish_test();
   end
endmodule
bind fbioc_top fbioc_top_asserts i_chk (.CLOCK(CLOCK), .SRST(SRST),
   .RX_VALID(RX_VALID), .TX_REQ(TX_REQ), .TX_VALID(TX_VALID),
   .TX_DATA(TX_DATA), .ALARM_CLEAR(ALARM_CLEAR),
   .SPEED_CMD_RPM(SPEED_CMD_RPM), .PARAM_WR_STB(PARAM_WR_STB),
   .PARAM_WR_CODE(PARAM_WR_CODE), .PARAM_WR_DATA(PARAM_WR_DATA));

// *** pkg/fbioc_cfg.svh ***
// offsets, field positions, reset values and codes of the i/o assembly codec
`ifndef FBIOC_CFG_SVH
`define FBIOC_CFG_SVH

// ==========================================================================
// register byte offsets (axi4-lite, one aligned word each)
`define FB_OFS_FMT 8'h00
`define FB_OFS_APPLY 8'h04
`define FB_OFS_WSEL01 8'h08
`define FB_OFS_WSEL23 8'h0c
`define FB_OFS_MAXSPD 8'h10
`define FB_OFS_LINK 8'h14
`define FB_OFS_DRVSTAT 8'h18
`define FB_OFS_MEAS 8'h1c
`define FB_OFS_CMDSTAT 8'h20

// ==========================================================================
// reset values
`define FB_RST_SEL 8'h00
`define FB_RST_WSEL 16'h0000
`define FB_RST_MAXSPD 16'h05dc
`define FB_RST_LINK 16'h0000
`define FB_RST_DRVSTAT 32'h0000_0000
`define FB_RST_MEAS 16'h0000

// ==========================================================================
// format selector codes
`define FB_OSEL_DEF 8'h00
`define FB_OSEL_EXT 8'h15
`define FB_OSEL_VEND 8'h64
`define FB_OSEL_ULINK 8'h66
`define FB_OSEL_U485 8'h6a
`define FB_ISEL_DEF 8'h00
`define FB_ISEL_EXT 8'h47
`define FB_ISEL_VEND 8'h65
`define FB_ISEL_ULINK 8'h67
`define FB_ISEL_U485 8'h6b

// ==========================================================================
// drive status register bit positions
`define FB_DS_ALARM 0
`define FB_DS_FWD 1
`define FB_DS_REV 2
`define FB_DS_READY 3
`define FB_DS_RUNNET 4
`define FB_DS_SPDNET 5
`define FB_DS_ATREF 6
`define FB_DS_DCBRK 7
`define FB_DS_SHUT 8
`define FB_DS_BRK 9
`define FB_DS_BUSOK 10
`define FB_DS_TLIM 11
`define FB_DS_VLIM 12
`define FB_DS_ILIM 13
`define FB_DS_ACC 14
`define FB_DS_DEC 15
`define FB_DS_PERR 16
`define FB_DS_PBUSY 17
`define FB_DS_STATE_LSB 24
`define FB_DS_STATE_MSB 26

// ==========================================================================
// drive state codes that mean the motor is being driven
`define FB_STATE_ACC 3'h4
`define FB_STATE_DEC 3'h5
`define FB_STATE_FDEC 3'h6

// ==========================================================================
// per-unit scale and bus responses
`define FB_PU_SCALE 34'sh0_4e20
`define FB_RESP_OKAY 2'h0
`define FB_RESP_SLVERR 2'h2
`define FB_RESP_DECERR 2'h3

`endif

// *** pkg/fbioc_pkg.sv ***
// types of the i/o assembly codec
package fbioc_pkg;
   // active output format
   typedef enum logic [3:0] {
      OUT_NONE = 4'b0001,
      OUT_EXT = 4'b0010,
      OUT_VEND = 4'b0100,
      OUT_USER = 4'b1000
   } fbioc_ofmt_type;
   // active input format
   typedef enum logic [3:0] {
      IN_NONE = 4'b0001,
      IN_EXT = 4'b0010,
      IN_VEND = 4'b0100,
      IN_USER = 4'b1000
   } fbioc_ifmt_type;
endpackage

// *** rtl/fbioc_top.sv ***
// i/o assembly codec: cyclic payload pack and unpack with axi4-lite setup
`timescale 1ns/1ps
`include "fbioc_cfg.svh"
module fbioc_top (
   // clock and reset
   input wire logic CLOCK,
   input wire logic SRST,
   // axi4-lite write channels
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   output logic [1:0] S_AXI_BRESP,
   // axi4-lite read channels
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   // network payloads, byte 0 in the low bits
   input wire logic RX_VALID,
   input wire logic [63:0] RX_DATA,
   input wire logic TX_REQ,
   output logic TX_VALID,
   output logic [63:0] TX_DATA,
   // drive commands
   output logic RUN_AHEAD,
   output logic RUN_BACKWARD,
   output logic ALARM_CLEAR,
   output logic NET_RUN_SOURCE_REQ,
   output logic NET_SPEED_SOURCE_REQ,
   output logic [15:0] SPEED_CMD_RPM,
   output logic [12:0] VIRTUAL_TERMINAL_CMDS,
   // parameter writes
   output logic [3:0] PARAM_WR_STB,
   output logic [63:0] PARAM_WR_CODE,
   output logic [63:0] PARAM_WR_DATA
);

   // =======================================================================
   // declarations
   logic awready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [7:0] out_sel_q, in_sel_q;
   logic [63:0] wsel_q;
   logic [15:0] max_speed_q, link_mode_q, meas_q;
   logic [31:0] drv_q;
   fbioc_pkg::fbioc_ofmt_type ofmt_q, ofmt_d;
   fbioc_pkg::fbioc_ifmt_type ifmt_q, ifmt_d;
   logic run_ahead_q, run_backward_q, alarm_clr_q;
   logic net_run_q, net_spd_q;
   logic [15:0] speed_q;
   logic [12:0] vterm_q;
   logic [3:0] pwr_stb_q;
   logic [63:0] pwr_code_q, pwr_data_q;
   logic tx_valid_q;
   logic [63:0] tx_data_q;

   // merge a write under its byte strobes
   function automatic logic [31:0] fbioc_merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // =======================================================================
   // axi4-lite decode
   wire wr_fire = awready_q && S_AXI_AWVALID && S_AXI_WVALID;
   wire rd_fire = arready_q && S_AXI_ARVALID;
   wire w_fmt = (S_AXI_AWADDR == `FB_OFS_FMT);
   wire w_apply = (S_AXI_AWADDR == `FB_OFS_APPLY);
   wire w_ws01 = (S_AXI_AWADDR == `FB_OFS_WSEL01);
   wire w_ws23 = (S_AXI_AWADDR == `FB_OFS_WSEL23);
   wire w_max = (S_AXI_AWADDR == `FB_OFS_MAXSPD);
   wire w_link = (S_AXI_AWADDR == `FB_OFS_LINK);
   wire w_drv = (S_AXI_AWADDR == `FB_OFS_DRVSTAT);
   wire w_meas = (S_AXI_AWADDR == `FB_OFS_MEAS);
   wire w_ro = (S_AXI_AWADDR == `FB_OFS_CMDSTAT);
   wire w_hit = w_fmt | w_apply | w_ws01 | w_ws23 | w_max | w_link
      | w_drv | w_meas;
   wire [1:0] bresp_d = w_hit ? `FB_RESP_OKAY :
      (w_ro ? `FB_RESP_SLVERR : `FB_RESP_DECERR);
   wire apply_stb = wr_fire && w_apply && S_AXI_WSTRB[0] && S_AXI_WDATA[0];

   // bit-field views of the pending write
   wire [31:0] fmt_m = fbioc_merge({16'h0000, in_sel_q, out_sel_q},
      S_AXI_WDATA, S_AXI_WSTRB);
   wire [31:0] ws01_m = fbioc_merge(wsel_q[31:0], S_AXI_WDATA, S_AXI_WSTRB);
   wire [31:0] ws23_m = fbioc_merge(wsel_q[63:32], S_AXI_WDATA,
      S_AXI_WSTRB);
   wire [31:0] max_m = fbioc_merge({16'h0000, max_speed_q}, S_AXI_WDATA,
      S_AXI_WSTRB);
   wire [31:0] link_m = fbioc_merge({16'h0000, link_mode_q}, S_AXI_WDATA,
      S_AXI_WSTRB);
   wire [31:0] drv_m = fbioc_merge(drv_q, S_AXI_WDATA, S_AXI_WSTRB);
   wire [31:0] meas_m = fbioc_merge({16'h0000, meas_q}, S_AXI_WDATA,
      S_AXI_WSTRB);

   // read mux; unused high bits read zero except in the drive status word
   wire [31:0] cmd_stat = {speed_q, 12'h000, net_spd_q, net_run_q,
      run_backward_q, run_ahead_q};
   wire [31:0] rd_mux =
      (S_AXI_ARADDR == `FB_OFS_FMT) ? {16'h0000, in_sel_q, out_sel_q} :
      (S_AXI_ARADDR == `FB_OFS_APPLY) ? {20'h00000, ifmt_q, 4'h0, ofmt_q} :
      (S_AXI_ARADDR == `FB_OFS_WSEL01) ? wsel_q[31:0] :
      (S_AXI_ARADDR == `FB_OFS_WSEL23) ? wsel_q[63:32] :
      (S_AXI_ARADDR == `FB_OFS_MAXSPD) ? {16'h0000, max_speed_q} :
      (S_AXI_ARADDR == `FB_OFS_LINK) ? {16'h0000, link_mode_q} :
      (S_AXI_ARADDR == `FB_OFS_DRVSTAT) ? drv_q :
      (S_AXI_ARADDR == `FB_OFS_MEAS) ? {16'h0000, meas_q} :
      (S_AXI_ARADDR == `FB_OFS_CMDSTAT) ? cmd_stat : 32'h0000_0000;
   wire rd_hit = (S_AXI_ARADDR <= `FB_OFS_CMDSTAT)
      && (S_AXI_ARADDR[1:0] == 2'h0);

   // =======================================================================
   // axi4-lite handshakes
   // ready waits for both address and data so one edge takes the pair
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         awready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `FB_RESP_OKAY;
      end else begin
         awready_q <= S_AXI_AWVALID && S_AXI_WVALID && !awready_q
            && !bvalid_q;
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= bresp_d;
         end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // read side answers in the cycle after the address is taken
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `FB_RESP_OKAY;
      end else begin
         arready_q <= S_AXI_ARVALID && !arready_q && !rvalid_q;
         if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_hit ? rd_mux : 32'h0000_0000;
            rresp_q <= rd_hit ? `FB_RESP_OKAY : `FB_RESP_DECERR;
         end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // =======================================================================
   // configuration and drive status registers
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         out_sel_q <= `FB_RST_SEL;
         in_sel_q <= `FB_RST_SEL;
         wsel_q <= {4{`FB_RST_WSEL}};
         max_speed_q <= `FB_RST_MAXSPD;
         link_mode_q <= `FB_RST_LINK;
         drv_q <= `FB_RST_DRVSTAT;
         meas_q <= `FB_RST_MEAS;
      end else if (wr_fire) begin
         if (w_fmt) begin
            out_sel_q <= fmt_m[7:0];
            in_sel_q <= fmt_m[15:8];
         end
         if (w_ws01) wsel_q[31:0] <= ws01_m;
         if (w_ws23) wsel_q[63:32] <= ws23_m;
         if (w_max) max_speed_q <= max_m[15:0];
         if (w_link) link_mode_q <= link_m[15:0];
         if (w_drv) drv_q <= drv_m;
         if (w_meas) meas_q <= meas_m[15:0];
      end
   end

   // =======================================================================
   // format selection
   wire o_ext = (out_sel_q == `FB_OSEL_DEF) || (out_sel_q == `FB_OSEL_EXT);
   wire i_ext = (in_sel_q == `FB_ISEL_DEF) || (in_sel_q == `FB_ISEL_EXT);
   // the link-numbered user format wins over a mixed serial one
   wire o_user = (out_sel_q == `FB_OSEL_ULINK)
      || ((out_sel_q == `FB_OSEL_U485) && (in_sel_q == `FB_ISEL_ULINK));
   wire i_user = (in_sel_q == `FB_ISEL_ULINK)
      || ((in_sel_q == `FB_ISEL_U485) && (out_sel_q == `FB_OSEL_ULINK));
   assign ofmt_d = o_ext ? fbioc_pkg::OUT_EXT :
      (out_sel_q == `FB_OSEL_VEND) ? fbioc_pkg::OUT_VEND :
      o_user ? fbioc_pkg::OUT_USER : fbioc_pkg::OUT_NONE;
   assign ifmt_d = i_ext ? fbioc_pkg::IN_EXT :
      (in_sel_q == `FB_ISEL_VEND) ? fbioc_pkg::IN_VEND :
      i_user ? fbioc_pkg::IN_USER : fbioc_pkg::IN_NONE;
   wire [2:0] drv_state = drv_q[`FB_DS_STATE_MSB:`FB_DS_STATE_LSB];
   wire running = (drv_state == `FB_STATE_ACC)
      || (drv_state == `FB_STATE_DEC) || (drv_state == `FB_STATE_FDEC);

   // selectors latch only on a restart request while the drive is stopped
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         ofmt_q <= fbioc_pkg::OUT_EXT;
         ifmt_q <= fbioc_pkg::IN_EXT;
      end else if (apply_stb && !running) begin
         ofmt_q <= ofmt_d;
         ifmt_q <= ifmt_d;
      end
   end

   // =======================================================================
   // output payload decode
   wire is_ext = (ofmt_q == fbioc_pkg::OUT_EXT);
   wire is_vend = (ofmt_q == fbioc_pkg::OUT_VEND);
   wire is_user = (ofmt_q == fbioc_pkg::OUT_USER);
   wire [7:0] rb0 = RX_DATA[7:0];
   wire [7:0] rb1 = RX_DATA[15:8];
   wire [15:0] rword = RX_DATA[31:16];
   // per-unit back to rpm; a zero maximum gives zero speed
   wire signed [15:0] rx_pu = $signed(rword);
   wire signed [33:0] rx_prod = rx_pu * $signed({1'b0, max_speed_q});
   wire signed [33:0] rx_rpm = rx_prod / `FB_PU_SCALE;
   wire [3:0] wr_en;
   wire drive_fmt = is_ext || is_vend;
   // byte 1 of the extended format and the unused bits are not looked at
   wire ahead_d = drive_fmt ? rb0[0] : run_ahead_q;
   wire backward_d = drive_fmt ? rb0[1] : run_backward_q;
   wire aclr_d = is_ext ? rb0[2] : (is_vend && rb1[7]);
   wire netrun_d = is_ext ? rb0[5] : (is_vend ? 1'b0 : net_run_q);
   wire netspd_d = is_ext ? rb0[6] : (is_vend ? 1'b0 : net_spd_q);
   wire [15:0] speed_d = is_ext ? rword :
      (is_vend ? rx_rpm[15:0] : speed_q);
   wire [12:0] vterm_d = is_vend ? {rb1[6:0], rb0[7:2]} :
      (is_ext ? 13'h0000 : vterm_q);

   fbioc_wsel u_wsel (
      .sel(wsel_q),
      .en(wr_en)
   );

   // every field loads on the same edge so a word is never torn
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         run_ahead_q <= 1'b0;
         run_backward_q <= 1'b0;
         net_run_q <= 1'b0;
         net_spd_q <= 1'b0;
         speed_q <= 16'h0000;
         vterm_q <= 13'h0000;
      end else if (RX_VALID) begin
         run_ahead_q <= ahead_d;
         run_backward_q <= backward_d;
         net_run_q <= netrun_d;
         net_spd_q <= netspd_d;
         speed_q <= speed_d;
         vterm_q <= vterm_d;
      end
   end

   // alarm clear and parameter writes are one-cycle strobes per frame
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         alarm_clr_q <= 1'b0;
         pwr_stb_q <= 4'h0;
         pwr_code_q <= 64'h0000_0000_0000_0000;
         pwr_data_q <= 64'h0000_0000_0000_0000;
      end else begin
         alarm_clr_q <= RX_VALID && aclr_d;
         pwr_stb_q <= (RX_VALID && is_user) ? wr_en : 4'h0;
         if (RX_VALID && is_user) begin
            pwr_code_q <= wsel_q;
            pwr_data_q <= RX_DATA;
         end
      end
   end

   // =======================================================================
   // input payload build
   // the divider is large but runs only on register values, not the bus
   wire signed [33:0] tx_prod = $signed(meas_q) * `FB_PU_SCALE;
   wire signed [33:0] max_s = $signed({18'h00000, max_speed_q});
   wire signed [33:0] tx_pu = (max_speed_q == 16'h0000) ? 34'sh0_0000 :
      tx_prod / max_s;
   wire [7:0] eb0 = {drv_q[`FB_DS_ATREF], drv_q[`FB_DS_SPDNET],
      drv_q[`FB_DS_RUNNET], drv_q[`FB_DS_READY],
      drv_q[`FB_DS_REV], drv_q[`FB_DS_FWD], 1'b0,
      drv_q[`FB_DS_ALARM]};
   wire [7:0] eb1 = {5'h00, drv_state};
   wire [7:0] vb0 = {drv_q[`FB_DS_VLIM], drv_q[`FB_DS_TLIM],
      drv_q[`FB_DS_BUSOK], drv_q[`FB_DS_BRK],
      drv_q[`FB_DS_SHUT], drv_q[`FB_DS_DCBRK],
      drv_q[`FB_DS_REV], drv_q[`FB_DS_FWD]};
   wire link_active = (link_mode_q != 16'h0000);
   wire [7:0] vb1 = {drv_q[`FB_DS_PBUSY], drv_q[`FB_DS_PERR], 1'b0,
      link_active, drv_q[`FB_DS_ALARM], drv_q[`FB_DS_DEC],
      drv_q[`FB_DS_ACC], drv_q[`FB_DS_ILIM]};
   wire [63:0] tx_ext = {32'h0000_0000, meas_q, eb1, eb0};
   wire [63:0] tx_vend = {32'h0000_0000, tx_pu[15:0], vb1, vb0};
   // user input formats are not built here and read as zero
   wire [63:0] tx_pay = (ifmt_q == fbioc_pkg::IN_EXT) ? tx_ext :
      ((ifmt_q == fbioc_pkg::IN_VEND) ? tx_vend :
      64'h0000_0000_0000_0000);

   // one poll captures the whole payload in a single edge
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         tx_valid_q <= 1'b0;
         tx_data_q <= 64'h0000_0000_0000_0000;
      end else begin
         tx_valid_q <= TX_REQ;
         if (TX_REQ) tx_data_q <= tx_pay;
      end
   end

   // =======================================================================
   // port drive, all straight from flops
   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = awready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;
   assign TX_VALID = tx_valid_q;
   assign TX_DATA = tx_data_q;
   assign RUN_AHEAD = run_ahead_q;
   assign RUN_BACKWARD = run_backward_q;
   assign ALARM_CLEAR = alarm_clr_q;
   assign NET_RUN_SOURCE_REQ = net_run_q;
   assign NET_SPEED_SOURCE_REQ = net_spd_q;
   assign SPEED_CMD_RPM = speed_q;
   assign VIRTUAL_TERMINAL_CMDS = vterm_q;
   assign PARAM_WR_STB = pwr_stb_q;
   assign PARAM_WR_CODE = pwr_code_q;
   assign PARAM_WR_DATA = pwr_data_q;
endmodule

// *** rtl/fbioc_wsel.sv ***
// write target selector arbitration for the user defined output format
`timescale 1ns/1ps
module fbioc_wsel (
   // four 16-bit selectors, selector 0 in the low bits
   input wire logic [63:0] sel,
   // enable per selector
   output logic [3:0] en
);
   genvar gi;
   // a selector is dropped when any higher-numbered one names the same target
   for (gi = 0; gi < 4; gi++) begin : g_en
      logic dup;
      always_comb begin
         dup = 1'b0;
         for (int j = gi + 1; j < 4; j++) begin
            if (sel[j*16 +: 16] == sel[gi*16 +: 16]) begin
               dup = 1'b1;
            end
         end
      end
      // code zero means unassigned
      assign en[gi] = (sel[gi*16 +: 16] != 16'h0000) && !dup;
   end
endmodule
